// File: fscr_pkg.sv
/*
 constants for the fanout buffer configuration register bank.
 assumes a single 100 MHz clock domain and byte-wide register indices.
*/
package fscr_pkg;
   // register indices carried in the smbus index byte
   localparam logic [7:0] IDX_GATE_LO = 8'h00;
   localparam logic [7:0] IDX_GATE_HI = 8'h01;
   localparam logic [7:0] IDX_EDGE_LO = 8'h02;
   localparam logic [7:0] IDX_EDGE_HI = 8'h03;
   localparam logic [7:0] IDX_RSVD = 8'h04;
   localparam logic [7:0] IDX_REV = 8'h05;
   localparam logic [7:0] IDX_CLASS = 8'h06;
   localparam logic [7:0] IDX_RDLEN = 8'h07;
   // field positions
   localparam int G0_OUT3 = 6;
   localparam int G0_OUT2 = 5;
   localparam int G0_OUT1 = 3;
   localparam int G0_OUT0 = 1;
   localparam int G1_OUT4 = 5;
   localparam int E2_OUT3 = 6;
   localparam int E2_OUT2 = 5;
   localparam int E2_OUT1 = 3;
   localparam int E2_OUT0 = 1;
   localparam int E3_OUT4 = 0;
   // values after reset; reserved bits keep these for ever
   localparam logic [7:0] GATE_LO_RST = 8'h6B;
   localparam logic [7:0] GATE_HI_RST = 8'h62;
   localparam logic [7:0] EDGE_LO_RST = 8'h6B;
   localparam logic [7:0] EDGE_HI_RST = 8'h41;
   localparam logic [7:0] RSVD_VAL = 8'hFF;
   localparam logic [7:0] RDLEN_RST = 8'h08;
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;
   // writable bits of each register
   localparam logic [7:0] GATE_LO_WMASK = 8'h6A;
   localparam logic [7:0] GATE_HI_WMASK = 8'h23;
   localparam logic [7:0] EDGE_LO_WMASK = 8'h6A;
   localparam logic [7:0] EDGE_HI_WMASK = 8'h01;
   localparam logic [7:0] RDLEN_WMASK = 8'h1F;
   typedef enum {S_IDLE, S_ADDR, S_RX, S_ACK, S_TX, S_MACK} fscr_state_t;
endpackage

// File: fscr_pin_cond.sv
/*
 smbus pin conditioning: three-stage synchronisers with agreement filter,
 plus start, stop and clock edge pulses.
 assumes scl and sda arrive asynchronously to ref_clk_i.
*/
`timescale 1ns/1ps
module fscr_pin_cond (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_f_o,
   output logic sda_f_o,
   output logic start_o,
   output logic stop_o,
   output logic rise_o,
   output logic fall_o
);
   import fscr_pkg::*;
   logic [2:0] scl_sync_reg, sda_sync_reg;
   logic scl_f_reg, sda_f_reg;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      end
   end

   // filtered level moves only when stages two and three agree
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
      end else begin
         if (scl_sync_reg[1] == scl_sync_reg[2]) scl_f_reg <= scl_sync_reg[2];
         if (sda_sync_reg[1] == sda_sync_reg[2]) sda_f_reg <= sda_sync_reg[2];
      end
   end

   always_comb begin
      scl_f_o = scl_f_reg;
      sda_f_o = sda_f_reg;
      start_o = scl_f_reg && sda_f_reg && sda_sync_reg[1] == sda_sync_reg[2]
                && !sda_sync_reg[2] && scl_sync_reg[2];
      stop_o = scl_f_reg && !sda_f_reg && sda_sync_reg[1] == sda_sync_reg[2]
               && sda_sync_reg[2] && scl_sync_reg[2];
      rise_o = !scl_f_reg && scl_sync_reg[1] == scl_sync_reg[2]
               && scl_sync_reg[2];
      fall_o = scl_f_reg && scl_sync_reg[1] == scl_sync_reg[2]
               && !scl_sync_reg[2];
   end
endmodule // fscr_pin_cond

// File: fscr_regs.sv
/*
 smbus slave holding the fanout buffer configuration and id registers.
 assumes an smbus host using indexed block write and block read, and
 active-low output enable pins that are asynchronous to ref_clk_i.
*/
`timescale 1ns/1ps
// How it works
// - gate bit zero forces output low regardless
// - byte 2 bits 6,5,3 pick out3..out1 edge rate
// - byte 3 bit 0 picks out4 edge rate
// - byte 4 always reads all ones
// - byte 5 fixed revision and maker code
// - byte 6 fixed class and part code
// - block write: index, count, data, all acknowledged
// - block read: count then bytes until host nack
module fscr_regs #(
   parameter logic [6:0] SLAVE_ADDR = 7'h6B,
   parameter logic [3:0] REV_CODE = 4'h3,   // arbitrary value
   parameter logic [3:0] MAKER_CODE = 4'hA, // arbitrary value
   parameter logic [1:0] CLASS_CODE = 2'h2, // arbitrary value
   parameter logic [5:0] PART_CODE = 6'h2A, // arbitrary value
   parameter int NUM_OUT = 5
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [NUM_OUT-1:0] out_en_n_i,
   output logic [NUM_OUT-1:0] out_run_o,
   output logic [NUM_OUT-1:0] edge_rate_o,
   output logic [1:0] amp_sel_o
);
   import fscr_pkg::*;
   logic scl_f, sda_f, start_p, stop_p, rise_p, fall_p;
   fscr_state_t state_reg, state_next;
   logic [7:0] shift_reg, shift_next;
   logic [2:0] bit_reg, bit_next;
   logic got8_reg, got8_next, rd_mode_reg, cnt_sent_reg;
   logic [1:0] wph_reg;
   logic [7:0] ptr_reg, wcnt_reg, rd_byte, tx_byte;
   logic [7:0] gate_lo_reg, gate_hi_reg, edge_lo_reg, edge_hi_reg, rdlen_reg;
   logic [NUM_OUT-1:0] gate_vec, edge_vec;
   logic [NUM_OUT-1:0] en_s1_reg, en_s2_reg, en_s3_reg, en_f_reg;
   logic byte_end, wr_en, load_tx;
   logic sda_oe_reg, sda_out_reg;
   logic [NUM_OUT-1:0] out_run_reg, edge_rate_reg;
   logic [1:0] amp_reg;
   fscr_pin_cond u_pins (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_f_o(scl_f),
      .sda_f_o(sda_f),
      .start_o(start_p),
      .stop_o(stop_p),
      .rise_o(rise_p),
      .fall_o(fall_p)
   );
   assign byte_end = fall_p && got8_reg;
   assign wr_en = state_reg == S_RX && byte_end && wph_reg == 2'h2
                  && wcnt_reg != 8'h00;
   assign load_tx = fall_p && state_next == S_TX && state_reg != S_TX;
   assign tx_byte = cnt_sent_reg ? rd_byte : rdlen_reg;
   // read view of the register at the current index
   always_comb begin
      if (ptr_reg == IDX_GATE_LO) rd_byte = gate_lo_reg;
      else if (ptr_reg == IDX_GATE_HI) rd_byte = gate_hi_reg;
      else if (ptr_reg == IDX_EDGE_LO) rd_byte = edge_lo_reg;
      else if (ptr_reg == IDX_EDGE_HI) rd_byte = edge_hi_reg;
      else if (ptr_reg == IDX_RSVD) rd_byte = RSVD_VAL;
      else if (ptr_reg == IDX_REV) rd_byte = {REV_CODE, MAKER_CODE};
      else if (ptr_reg == IDX_CLASS) rd_byte = {CLASS_CODE, PART_CODE};
      else if (ptr_reg == IDX_RDLEN) rd_byte = rdlen_reg;
      else rd_byte = UNMAPPED_VAL;
   end
   always_comb begin
      state_next = state_reg;
      if (stop_p) state_next = S_IDLE;
      else if (start_p) state_next = S_ADDR;
      else begin
         case (state_reg)
            S_ADDR: if (byte_end) begin
               state_next = shift_reg[7:1] == SLAVE_ADDR ? S_ACK : S_IDLE;
            end
            S_RX: if (byte_end) state_next = S_ACK;
            S_ACK: if (fall_p) state_next = rd_mode_reg ? S_TX : S_RX;
            S_TX: if (fall_p && bit_reg == 3'h7) state_next = S_MACK;
            S_MACK: begin
               if (rise_p && sda_f) state_next = S_IDLE;
               else if (fall_p) state_next = S_TX;
            end
            default: state_next = state_reg;
         endcase
      end
   end
   always_comb begin
      shift_next = shift_reg;
      bit_next = bit_reg;
      got8_next = got8_reg;
      if (start_p || stop_p) begin
         bit_next = 3'h0;
         got8_next = 1'b0;
      end else if ((state_reg == S_ADDR || state_reg == S_RX) && rise_p) begin
         shift_next = {shift_reg[6:0], sda_f};
         bit_next = bit_reg + 3'h1;
         got8_next = bit_reg == 3'h7;
      end else if (fall_p) begin
         got8_next = 1'b0;
         if (load_tx) begin
            shift_next = tx_byte;
            bit_next = 3'h0;
         end else if (state_reg == S_TX) begin
            shift_next = {shift_reg[6:0], 1'b0};
            bit_next = bit_reg + 3'h1;
         end
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= S_IDLE;
         shift_reg <= 8'h00;
         bit_reg <= 3'h0;
         got8_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         sda_out_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         bit_reg <= bit_next;
         got8_reg <= got8_next;
         // open drain: pull low for ack and for zero data bits
         sda_oe_reg <= state_next == S_ACK
                       || (state_next == S_TX && !shift_next[7]);
         sda_out_reg <= 1'b0;
      end
   end
   // transfer bookkeeping: index, write count, read phase
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rd_mode_reg <= 1'b0;
         cnt_sent_reg <= 1'b0;
         wph_reg <= 2'h0;
         ptr_reg <= 8'h00;
         wcnt_reg <= 8'h00;
      end else if (state_reg == S_ADDR && byte_end) begin
         rd_mode_reg <= shift_reg[0];
         cnt_sent_reg <= 1'b0;
         wph_reg <= 2'h0;
      end else if (state_reg == S_RX && byte_end) begin
         if (wph_reg == 2'h0) begin
            ptr_reg <= shift_reg;
            wph_reg <= 2'h1;
         end else if (wph_reg == 2'h1) begin
            wcnt_reg <= shift_reg;
            wph_reg <= 2'h2;
         end else if (wr_en) begin
            ptr_reg <= ptr_reg + 8'h01;
            wcnt_reg <= wcnt_reg - 8'h01;
         end
      end else if (load_tx) begin
         if (!cnt_sent_reg) cnt_sent_reg <= 1'b1;
         else ptr_reg <= ptr_reg + 8'h01;
      end
   end
   // writable fields; reserved and read-only bits never change
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         gate_lo_reg <= GATE_LO_RST;
         gate_hi_reg <= GATE_HI_RST;
         edge_lo_reg <= EDGE_LO_RST;
         edge_hi_reg <= EDGE_HI_RST;
         rdlen_reg <= RDLEN_RST;
      end else if (wr_en) begin
         if (ptr_reg == IDX_GATE_LO) begin
            gate_lo_reg <= (gate_lo_reg & ~GATE_LO_WMASK)
                           | (shift_reg & GATE_LO_WMASK);
         end else if (ptr_reg == IDX_GATE_HI) begin
            gate_hi_reg <= (gate_hi_reg & ~GATE_HI_WMASK)
                           | (shift_reg & GATE_HI_WMASK);
         end else if (ptr_reg == IDX_EDGE_LO) begin
            edge_lo_reg <= (edge_lo_reg & ~EDGE_LO_WMASK)
                           | (shift_reg & EDGE_LO_WMASK);
         end else if (ptr_reg == IDX_EDGE_HI) begin
            edge_hi_reg <= (edge_hi_reg & ~EDGE_HI_WMASK)
                           | (shift_reg & EDGE_HI_WMASK);
         end else if (ptr_reg == IDX_RDLEN) begin
            rdlen_reg <= shift_reg & RDLEN_WMASK;
         end
      end
   end

   assign gate_vec = {gate_hi_reg[G1_OUT4], gate_lo_reg[G0_OUT3],
                      gate_lo_reg[G0_OUT2], gate_lo_reg[G0_OUT1],
                      gate_lo_reg[G0_OUT0]};
   assign edge_vec = {edge_hi_reg[E3_OUT4], edge_lo_reg[E2_OUT3],
                      edge_lo_reg[E2_OUT2], edge_lo_reg[E2_OUT1],
                      edge_lo_reg[E2_OUT0]};

   // enable pins: three stages, level moves when stages two and three agree
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         en_s1_reg <= '1;
         en_s2_reg <= '1;
         en_s3_reg <= '1;
         en_f_reg <= '1;
      end else begin
         en_s1_reg <= out_en_n_i;
         en_s2_reg <= en_s1_reg;
         en_s3_reg <= en_s2_reg;
         en_f_reg <= (en_s2_reg & en_s3_reg)
                     | (en_f_reg & (en_s2_reg ^ en_s3_reg));
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         out_run_reg <= '0;
         edge_rate_reg <= '1;
         amp_reg <= GATE_HI_RST[1:0];
      end else begin
         out_run_reg <= gate_vec & ~en_f_reg;
         edge_rate_reg <= edge_vec;
         amp_reg <= gate_hi_reg[1:0];
      end
   end

   assign sda_o = sda_out_reg;
   assign sda_oe_o = sda_oe_reg;
   assign out_run_o = out_run_reg;
   assign edge_rate_o = edge_rate_reg;
   assign amp_sel_o = amp_reg;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_gate_low;
      ((out_run_o & ~$past(gate_vec)) == '0);
   endproperty
   a_gate_low: assert property (p_gate_low)
      else $error("output running while its gate bit is zero");
   property p_edge_mid;
      ##1 edge_rate_o[3:1] == $past({edge_lo_reg[E2_OUT3],
         edge_lo_reg[E2_OUT2], edge_lo_reg[E2_OUT1]});
   endproperty
   a_edge_mid: assert property (p_edge_mid)
      else $error("edge rate of outputs 3..1 mismatches byte 2");
   property p_edge_out0;
      $changed(edge_lo_reg[E2_OUT0]) |=> $changed(edge_rate_o[0]);
   endproperty
   a_edge_out0: assert property (p_edge_out0)
      else $error("edge rate of output 0 did not follow byte 2");
   property p_edge_out4;
      $past(sys_rst_i) |-> edge_hi_reg[E3_OUT4] ##1 edge_rate_o[4];
   endproperty
   a_edge_out4: assert property (p_edge_out4)
      else $error("edge rate of output 4 not fast after reset");
   property p_rsvd;
      load_tx && cnt_sent_reg && ptr_reg == IDX_RSVD |=> shift_reg == 8'hFF;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved byte does not read all ones");
   property p_rev;
      load_tx && cnt_sent_reg && ptr_reg == IDX_REV
         |=> shift_reg == {REV_CODE, MAKER_CODE};
   endproperty
   a_rev: assert property (p_rev)
      else $error("revision byte not fixed");
   property p_class;
      load_tx && cnt_sent_reg && ptr_reg == IDX_CLASS
         |=> shift_reg == {CLASS_CODE, PART_CODE};
   endproperty
   a_class: assert property (p_class)
      else $error("class byte not fixed");
   property p_rdlen;
      rdlen_reg[7:5] == 3'h0 && (!$past(sys_rst_i) || rdlen_reg == 8'h08);
   endproperty
   a_rdlen: assert property (p_rdlen)
      else $error("readback length out of range or wrong default");
   property p_ack;
      state_reg == S_ACK |-> sda_oe_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledge not driven low");
   property p_nack;
      state_reg == S_MACK && rise_p && sda_f && !stop_p && !start_p
         |=> state_reg == S_IDLE ##1 !sda_oe_o;
   endproperty
   a_nack: assert property (p_nack)
      else $error("host nack did not end the read");
   c_write: cover property (wr_en ##[1:300] stop_p);
   c_read_nack: cover property (state_reg == S_MACK && rise_p && sda_f);
   c_restart: cover property (state_reg == S_RX ##[1:400] start_p);
endmodule // fscr_regs

// File: fscr_host_model.sv
/*
 smbus host model issuing indexed block write and block read transfers.
 assumes sda is resolved outside as an open drain with a pull-up.
*/
`timescale 1ns/1ps
module fscr_host_model #(
   parameter logic [6:0] ADDR = 7'h6B,
   parameter int HALF = 12
) (
   input wire logic ref_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic start_c();
      sda_low_o = 1'b0;
      tick(HALF);
      scl_o = 1'b1;
      tick(HALF);
      sda_low_o = 1'b1;
      tick(HALF);
      scl_o = 1'b0;
   endtask
   task automatic stop_c();
      tick(4);
      sda_low_o = 1'b1;
      tick(HALF);
      scl_o = 1'b1;
      tick(HALF);
      sda_low_o = 1'b0;
      tick(HALF);
   endtask
   // data set after scl fall, sampled as scl rises
   task automatic bit_c(input logic drv_low, output logic s);
      tick(4);
      sda_low_o = drv_low;
      tick(HALF);
      scl_o = 1'b1;
      s = sda_i;
      tick(HALF);
      scl_o = 1'b0;
   endtask
   task automatic put_byte(input logic [7:0] b, inout int nacks);
      logic s;
      for (int i = 7; i >= 0; i--) bit_c(~b[i], s);
      bit_c(1'b0, s);
      if (s !== 1'b0) nacks++;
   endtask
   task automatic get_byte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b0, s);
         b[i] = s;
      end
      bit_c(ack, s);
   endtask
   task automatic block_write(input logic [6:0] a, input logic [7:0] idx,
         input logic [7:0] n, input logic [31:0] d, output int nacks);
      nacks = 0;
      start_c();
      put_byte({a, 1'b0}, nacks);
      put_byte(idx, nacks);
      put_byte(n, nacks);
      for (int i = 0; i < n; i++) put_byte(d[8*i+:8], nacks);
      stop_c();
   endtask
   task automatic block_read(input logic [7:0] idx, input logic [7:0] n,
         output logic [7:0] cnt, output logic [31:0] d);
      int nk;
      logic [7:0] b;
      nk = 0;
      d = '0;
      start_c();
      put_byte({ADDR, 1'b0}, nk);
      put_byte(idx, nk);
      start_c();
      put_byte({ADDR, 1'b1}, nk);
      get_byte(1'b1, cnt);
      for (int i = 0; i < n; i++) begin
         get_byte(logic'(i < n - 1), b);
         d[8*i+:8] = b;
      end
      stop_c();
   endtask
endmodule // fscr_host_model

// File: tb.sv
/*
 self-checking bench for the configuration register bank.
 assumes the host model drives scl and pulls sda through an open drain.
*/
`timescale 1ns/1ps
module tb;
   import fscr_pkg::*;
   typedef struct packed {
      logic [7:0] idx, wr, rd;
      logic [4:0] er, run;
   } fscr_row_t;
   localparam fscr_row_t ROWS [14] = '{
      '{8'h02, 8'h00, 8'h01, 5'h10, 5'h1F},
      '{8'h03, 8'h00, 8'h40, 5'h00, 5'h1F},
      '{8'h02, 8'hFF, 8'h6B, 5'h0F, 5'h1F},
      '{8'h03, 8'hFF, 8'h41, 5'h1F, 5'h1F},
      '{8'h00, 8'h00, 8'h01, 5'h1F, 5'h10},
      '{8'h00, 8'hFF, 8'h6B, 5'h1F, 5'h1F},
      '{8'h01, 8'h00, 8'h40, 5'h1F, 5'h0F},
      '{8'h01, 8'h23, 8'h63, 5'h1F, 5'h1F},
      '{8'h04, 8'h00, 8'hFF, 5'h1F, 5'h1F},
      '{8'h05, 8'h00, 8'h3A, 5'h1F, 5'h1F},
      '{8'h06, 8'h00, 8'hAA, 5'h1F, 5'h1F},
      '{8'h07, 8'hFF, 8'h1F, 5'h1F, 5'h1F},
      '{8'h07, 8'h08, 8'h08, 5'h1F, 5'h1F},
      '{8'h09, 8'h55, 8'h00, 5'h1F, 5'h1F}
   };
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [4:0] out_en_n_i = 5'h1F;
   logic scl, host_low, sda_o, sda_oe_o;
   logic [4:0] out_run_o, edge_rate_o;
   logic [1:0] amp_sel_o;
   wire sda = ~(host_low | (sda_oe_o & ~sda_o));
   int errors = 0;
   int samples_checked = 0;
   int nacks;
   logic [7:0] cnt, cnt_exp;
   logic [31:0] d;
   always #5 ref_clk_i = ~ref_clk_i;
   fscr_regs uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .out_en_n_i(out_en_n_i), .out_run_o(out_run_o),
      .edge_rate_o(edge_rate_o), .amp_sel_o(amp_sel_o));
   fscr_host_model host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl),
      .sda_low_o(host_low));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   initial begin
      #1_000_000;
      errors++;
      stop_test();
   end
   initial begin
      wait_clk(16);
      check(8'(edge_rate_o), 8'h1F);
      check(8'(out_run_o), 8'h00);
      check(8'(sda_oe_o), 8'h00);
      check(8'(amp_sel_o), 8'h02);
      $display("reset done");
      sys_rst_i = 1'b0;
      out_en_n_i = 5'h00;
      wait_clk(10);
      cnt_exp = RDLEN_RST;
      foreach (ROWS[i]) begin
         host.block_write(7'h6B, ROWS[i].idx, 8'h01, 32'(ROWS[i].wr), nacks);
         check(8'(nacks), 8'h00);
         host.block_read(ROWS[i].idx, 8'h01, cnt, d);
         if (ROWS[i].idx == IDX_RDLEN) cnt_exp = ROWS[i].rd;
         check(cnt, cnt_exp);
         check(d[7:0], ROWS[i].rd);
         check(8'(edge_rate_o), 8'(ROWS[i].er));
         check(8'(out_run_o), 8'(ROWS[i].run));
         $display("row %0d done", i);
      end
      check(8'(amp_sel_o), 8'h03);
      // two-byte write, then four-byte read walking the index
      host.block_write(7'h6B, IDX_EDGE_LO, 8'h02, 32'h0, nacks);
      host.block_read(IDX_EDGE_LO, 8'h04, cnt, d);
      check(8'(nacks), 8'h00);
      check(d[7:0], 8'h01);
      check(d[15:8], 8'h40);
      check(d[23:16], RSVD_VAL);
      check(d[31:24], 8'h3A);
      check(8'(edge_rate_o), 8'h00);
      $display("burst done");
      // foreign address must be ignored
      host.block_write(7'h6C, IDX_EDGE_LO, 8'h01, 32'hFF, nacks);
      host.block_read(IDX_EDGE_LO, 8'h01, cnt, d);
      check(8'(nacks), 8'h04);
      check(d[7:0], 8'h01);
      $display("foreign address done");
      out_en_n_i = 5'h1E;
      wait_clk(10);
      check(8'(out_run_o), 8'h01);
      host.block_write(7'h6B, IDX_GATE_LO, 8'h01, 32'h0, nacks);
      check(8'(out_run_o), 8'h00);
      $display("gate override done");
      sys_rst_i = 1'b1;
      wait_clk(4);
      check(8'(edge_rate_o), 8'h1F);
      check(8'(sda_oe_o), 8'h00);
      check(8'(amp_sel_o), 8'h02);
      sys_rst_i = 1'b0;
      out_en_n_i = 5'h00;
      wait_clk(10);
      host.block_read(IDX_EDGE_LO, 8'h01, cnt, d);
      check(cnt, RDLEN_RST);
      check(d[7:0], EDGE_LO_RST);
      check(8'(out_run_o), 8'h1F);
      $display("second reset done");
      // a data byte past the count is acked and dropped
      nacks = 0;
      host.start_c();
      host.put_byte({7'h6B, 1'b0}, nacks);
      host.put_byte(IDX_EDGE_LO, nacks);
      host.put_byte(8'h01, nacks);
      host.put_byte(8'h00, nacks);
      host.put_byte(8'h00, nacks);
      host.stop_c();
      host.block_read(IDX_EDGE_LO, 8'h02, cnt, d);
      check(8'(nacks), 8'h00);
      check(d[7:0], 8'h01);
      check(d[15:8], EDGE_HI_RST);
      check(8'(edge_rate_o), 8'h10);
      $display("overrun done");
      stop_test();
   end
endmodule // tb
